/* File: a2c_clkgen.sv */
// Clock generator for the second serial audio port: source select,
// bit and word dividers, output multiplexers and register file.
// Assumes source clocks are asynchronous levels; port 1 divider and
// DAC clocks come from logic on clock_i.
`timescale 1ns/1ps
module a2c_clkgen (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire a2c_pkg::a2c_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Divider source clocks, asynchronous
  input wire logic n_divider_clock_i,
  input wire logic dac_modulator_clock_i,
  input wire logic adc_modulator_clock_i,
  input wire logic port1_bitclk_pin_i,
  input wire logic port2_bitclk_pin_i,
  // First port clocks and second port DAC clock, same clock domain
  input wire logic port1_bitdiv_clk_i,
  input wire logic port1_worddiv_clk_i,
  input wire logic port1_dac_clk_i,
  input wire logic port2_dac_clk_i,
  // Second port clock outputs
  output logic port2_bitclk_o,
  output logic port2_wordclk_o
);

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] filt;
    logic [7:0] bitdiv_source;
    logic [7:0] bitdiv_ratio_power;
    logic [7:0] worddiv_ratio_power;
    logic [7:0] clock_output_select;
    logic [7:0] rdata;
    logic bclk;
    logic wclk;
  } a2c_top_s;

  a2c_top_s st_r;
  a2c_top_s st_nxt;
  localparam int NUM_LANES = a2c_pkg::NUM_SRC;
  logic [NUM_LANES-1:0] raw_src;
  logic [NUM_LANES-1:0] edge_src;
  logic [NUM_LANES-1:0] filt_nxt;
  logic sel_valid;
  logic [2:0] sel_lane;
  logic sel_level;
  logic sel_step;
  logic bit_clock_divider_clk;
  logic bit_clock_divider_tick;
  logic word_clock_divider_clk;
  logic [3:0] sel_code;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Map a divider input code to its sync lane; bit 3 flags a valid code
  function automatic logic [3:0] src_lane(input logic [2:0] code);
    case (code)
      a2c_pkg::SRC_N_DIVIDER: src_lane = 4'h8;
      a2c_pkg::SRC_DAC_MOD: src_lane = 4'h9;
      a2c_pkg::SRC_ADC_MOD: src_lane = 4'hA;
      a2c_pkg::SRC_PORT1_PIN: src_lane = 4'hB;
      a2c_pkg::SRC_PORT2_PIN: src_lane = 4'hC;
      default: src_lane = 4'h0;
    endcase
  endfunction

  // Pick an output clock by output source code; reserved gives low
  function automatic logic out_pick(input logic [2:0] code, input logic p1_div, input logic p1_dac,
                                    input logic p2_div, input logic p2_dac);
    case (code)
      a2c_pkg::OUT_PORT1_DIV: out_pick = p1_div;
      a2c_pkg::OUT_PORT1_DAC: out_pick = p1_dac;
      a2c_pkg::OUT_PORT2_DIV: out_pick = p2_div;
      a2c_pkg::OUT_PORT2_DAC: out_pick = p2_dac;
      default: out_pick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------
  assign raw_src = {port2_bitclk_pin_i, port1_bitclk_pin_i, adc_modulator_clock_i,
                    dac_modulator_clock_i, n_divider_clock_i};

  // Per lane: accept a level once stages two and three agree
  generate
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
      assign filt_nxt[i] = (st_r.sync2[i] == st_r.sync3[i]) ? st_r.sync3[i] : st_r.filt[i];
      assign edge_src[i] = filt_nxt[i] & ~st_r.filt[i];
    end
  endgenerate

  // Selected divider input
  assign sel_code = src_lane(st_r.bitdiv_source[a2c_pkg::SRC_SEL_MSB:0]);
  // Reserved codes leave the divider without steps
  assign sel_valid = sel_code[3];
  assign sel_lane = sel_code[2:0];
  assign sel_level = sel_valid & st_r.filt[sel_lane];
  assign sel_step = sel_valid & edge_src[sel_lane];

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  // Bit clock divider
  a2c_divider u_bitdiv (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .power_i(st_r.bitdiv_ratio_power[a2c_pkg::POWER_BIT]),
    .ratio_i(st_r.bitdiv_ratio_power[a2c_pkg::RATIO_MSB:0]),
    .src_i(sel_level),
    .step_i(sel_step),
    .clk_o(bit_clock_divider_clk),
    .tick_o(bit_clock_divider_tick)
  );

  // Word clock divider, stepped once per bit clock period
  a2c_divider u_worddiv (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .power_i(st_r.worddiv_ratio_power[a2c_pkg::POWER_BIT]),
    .ratio_i(st_r.worddiv_ratio_power[a2c_pkg::RATIO_MSB:0]),
    .src_i(bit_clock_divider_clk),
    .step_i(bit_clock_divider_tick),
    .clk_o(word_clock_divider_clk),
    .tick_o()
  );

  // ----------------------------------------
  // Next state: sync, registers, read data, outputs
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = raw_src;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync3 = st_r.sync2;
    st_nxt.filt = filt_nxt;
    // Register writes, all eight bits stored
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        a2c_pkg::ADDR_BITDIV_SOURCE: st_nxt.bitdiv_source = reg_req_i.wdata;
        a2c_pkg::ADDR_BITDIV_RATIO_POWER: st_nxt.bitdiv_ratio_power = reg_req_i.wdata;
        a2c_pkg::ADDR_WORDDIV_RATIO_POWER: st_nxt.worddiv_ratio_power = reg_req_i.wdata;
        a2c_pkg::ADDR_CLOCK_OUTPUT_SELECT: st_nxt.clock_output_select = reg_req_i.wdata;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // Register reads, unmapped gives zero
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        a2c_pkg::ADDR_BITDIV_SOURCE: st_nxt.rdata = st_r.bitdiv_source;
        a2c_pkg::ADDR_BITDIV_RATIO_POWER: st_nxt.rdata = st_r.bitdiv_ratio_power;
        a2c_pkg::ADDR_WORDDIV_RATIO_POWER: st_nxt.rdata = st_r.worddiv_ratio_power;
        a2c_pkg::ADDR_CLOCK_OUTPUT_SELECT: st_nxt.rdata = st_r.clock_output_select;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // Output multiplexers
    st_nxt.bclk = out_pick(st_r.clock_output_select[a2c_pkg::BCLK_SEL_MSB:a2c_pkg::BCLK_SEL_LSB],
                           port1_bitdiv_clk_i, port1_dac_clk_i, bit_clock_divider_clk, port2_dac_clk_i);
    st_nxt.wclk = out_pick(st_r.clock_output_select[a2c_pkg::WCLK_SEL_MSB:0],
                           port1_worddiv_clk_i, port1_dac_clk_i, word_clock_divider_clk, port2_dac_clk_i);
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.bitdiv_source <= a2c_pkg::RST_BITDIV_SOURCE;
      st_r.bitdiv_ratio_power <= a2c_pkg::RST_BITDIV_RATIO_POWER;
      st_r.worddiv_ratio_power <= a2c_pkg::RST_WORDDIV_RATIO_POWER;
      st_r.clock_output_select <= a2c_pkg::RST_CLOCK_OUTPUT_SELECT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign port2_bitclk_o = st_r.bclk;
  assign port2_wordclk_o = st_r.wclk;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_reset_values: assert property ($past(sys_rst_i) |-> st_r.bitdiv_source == a2c_pkg::RST_BITDIV_SOURCE &&
    st_r.bitdiv_ratio_power == a2c_pkg::RST_BITDIV_RATIO_POWER &&
    st_r.worddiv_ratio_power == a2c_pkg::RST_WORDDIV_RATIO_POWER &&
    st_r.clock_output_select == a2c_pkg::RST_CLOCK_OUTPUT_SELECT)
    else $error("register reset value wrong");
  chk_src_reserved_rw: assert property (reg_req_i.wr && reg_req_i.addr == 8'h21 ##1 reg_req_i.rd &&
    reg_req_i.addr == 8'h21 && !reg_req_i.wr |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
    else $error("source register did not read back all bits");
  chk_unmapped_read: assert property (reg_req_i.rd && reg_req_i.addr > 8'h24 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  // Read data stands until the next read
  chk_rdata_hold: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  chk_src_step: assert property (st_r.bitdiv_source == 8'h06 |-> sel_step == edge_src[4])
    else $error("second port pin not routed to divider");
  chk_bit_clock_divider_off: assert property (!st_r.bitdiv_ratio_power[7] [*2] |-> !bit_clock_divider_clk && !bit_clock_divider_tick)
    else $error("bit divider runs while powered down");
  chk_word_clock_divider_off: assert property (!st_r.worddiv_ratio_power[7] [*2] |-> !word_clock_divider_clk)
    else $error("word divider runs while powered down");
  chk_bclk_mux: assert property (st_r.clock_output_select[6:4] == 3'h3 |=> port2_bitclk_o == $past(bit_clock_divider_clk))
    else $error("bit clock output not from bit divider");
  chk_wclk_mux: assert property (st_r.clock_output_select[2:0] == 3'h4 |=> port2_wordclk_o == $past(port2_dac_clk_i))
    else $error("word clock output not from dac clock");
  chk_reserved_low: assert property (st_r.clock_output_select[6:4] == 3'h2 |=> !port2_bitclk_o)
    else $error("reserved bit clock source not held low");
  chk_word_step: assert property (bit_clock_divider_tick && st_r.worddiv_ratio_power == 8'h81 |=> ##1 $rose(word_clock_divider_clk) || word_clock_divider_clk)
    else $error("word divider not stepped by bit divider");

  cov_bclk_toggle: cover property (st_r.bitdiv_ratio_power[7] && $rose(port2_bitclk_o));
  cov_wclk_toggle: cover property (st_r.worddiv_ratio_power[7] && $rose(port2_wordclk_o));
  cov_pin_source: cover property (st_r.bitdiv_source[2:0] == 3'h4 && sel_step);

endmodule

/* File: a2c_divider.sv */
// Programmable divider with power control and 7-bit ratio.
// Assumes step_i is a one-cycle pulse per input rising edge on clock_i.
`timescale 1ns/1ps
module a2c_divider (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic power_i,
  input wire logic [6:0] ratio_i,
  // Input clock as level and rising-edge pulse
  input wire logic src_i,
  input wire logic step_i,
  // Divided clock and wrap pulse
  output logic clk_o,
  output logic tick_o
);

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
    logic tick;
  } a2c_div_s;

  a2c_div_s st_r;
  a2c_div_s st_nxt;
  logic [7:0] div_n;
  logic [7:0] half_n;

  // Divisor from ratio code
  assign div_n = (ratio_i == 7'h00) ? a2c_pkg::RATIO_ZERO_DIVISOR : {1'b0, ratio_i};
  assign half_n = 8'((9'(div_n) + 9'h001) >> 1);

  // Count input edges, wrap at divisor
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!power_i) begin
      st_nxt.cnt = 8'h00;
      st_nxt.out = 1'b0;
    end else begin
      if (step_i) begin
        if (st_r.cnt >= 8'(div_n - 8'h01)) begin
          st_nxt.cnt = 8'h00;
          st_nxt.tick = 1'b1;
        end else begin
          st_nxt.cnt = 8'(st_r.cnt + 8'h01);
        end
      end
      // Divide by one passes the input through
      st_nxt.out = (div_n == 8'h01) ? src_i : (st_nxt.cnt < half_n);
    end
  end

  // State register
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign clk_o = st_r.out;
  assign tick_o = st_r.tick;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_power_off_idle: assert property (!power_i |=> (st_r.cnt == 8'h00) && !clk_o && !tick_o)
    else $error("divider active while powered down");
  chk_tick_at_wrap: assert property (power_i && step_i && $stable(ratio_i) && (st_r.cnt == 8'(div_n - 8'h01))
    |=> tick_o && (st_r.cnt == 8'h00))
    else $error("divider did not wrap at ratio");
  chk_no_early_tick: assert property (tick_o |-> $past(st_r.cnt) >= 8'($past(div_n) - 8'h01))
    else $error("divider wrapped early");
  cov_full_wrap: cover property (power_i && step_i && ratio_i == 7'h00 && st_r.cnt == 8'h7F);

endmodule

/* File: a2c_host_clk_mon.sv */
// Far-side receiver of one audio port clock: measures rising-edge periods.
// Assumes the watched clock is a level sampled on clock_i.
`timescale 1ns/1ps
module a2c_host_clk_mon (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Watched clock
  input wire logic clk_in_i,
  // Period in cycles, its valid pulse, edge count
  output int per_o,
  output logic meas_o,
  output int edges_o
);
  logic prev_r;
  int cnt_r;
  // Period counter, restarts on each rising edge
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_r <= 1'b0;
      cnt_r <= 0;
      per_o <= 0;
      meas_o <= 1'b0;
      edges_o <= 0;
    end else begin
      prev_r <= clk_in_i;
      meas_o <= 1'b0;
      cnt_r <= cnt_r + 1;
      if (clk_in_i && !prev_r) begin
        per_o <= cnt_r + 1;
        cnt_r <= 0;
        meas_o <= (edges_o > 0); // First edge has no full period
        edges_o <= edges_o + 1;
      end
    end
  end
endmodule

/* File: a2c_pkg.sv */
// Package for the second audio port clock generator: register map,
// field layout, reset values, source codes and bus carrier struct.
// Assumes an 8-bit register port driven from logic on clock_i.
package a2c_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_BITDIV_SOURCE = 8'h21;
  localparam logic [7:0] ADDR_BITDIV_RATIO_POWER = 8'h22;
  localparam logic [7:0] ADDR_WORDDIV_RATIO_POWER = 8'h23;
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_SELECT = 8'h24;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BITDIV_SOURCE = 8'h01;
  localparam logic [7:0] RST_BITDIV_RATIO_POWER = 8'h02;
  localparam logic [7:0] RST_WORDDIV_RATIO_POWER = 8'h20;
  localparam logic [7:0] RST_CLOCK_OUTPUT_SELECT = 8'h33;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POWER_BIT = 7;
  localparam int RATIO_MSB = 6;
  localparam int SRC_SEL_MSB = 2;
  localparam int BCLK_SEL_MSB = 6;
  localparam int BCLK_SEL_LSB = 4;
  localparam int WCLK_SEL_MSB = 2;

  // Divisor used for ratio code zero
  localparam logic [7:0] RATIO_ZERO_DIVISOR = 8'h80;

  // ----------------------------------------
  // Divider input codes and number of sync lanes
  // ----------------------------------------
  localparam logic [2:0] SRC_N_DIVIDER = 3'h0;
  localparam logic [2:0] SRC_DAC_MOD = 3'h1;
  localparam logic [2:0] SRC_ADC_MOD = 3'h3;
  localparam logic [2:0] SRC_PORT1_PIN = 3'h4;
  localparam logic [2:0] SRC_PORT2_PIN = 3'h6;
  localparam int NUM_SRC = 5;

  // ----------------------------------------
  // Output source codes
  // ----------------------------------------
  localparam logic [2:0] OUT_PORT1_DIV = 3'h0;
  localparam logic [2:0] OUT_PORT1_DAC = 3'h1;
  localparam logic [2:0] OUT_PORT2_DIV = 3'h3;
  localparam logic [2:0] OUT_PORT2_DAC = 3'h4;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } a2c_req_s;

endpackage

/* File: tb_top.sv */
// Self-checking bench for the second audio port clock generator.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  a2c_pkg::a2c_req_s req = '0;
  logic [7:0] rdata;
  logic [7:0] cyc = 8'h00;
  logic bclk, wclk, bv, wv;
  logic rd1 = 1'b0;
  logic [15:0] lf = 16'h6BE9;
  int bp, wp, be, we, error_cnt = 0, samples_checked = 0, tmo = 0;
  logic [7:0] rq[$];
  int bq[$];
  int wq[$];
  logic [7:0] ad[4] = '{a2c_pkg::ADDR_BITDIV_SOURCE, a2c_pkg::ADDR_BITDIV_RATIO_POWER,
    a2c_pkg::ADDR_WORDDIV_RATIO_POWER, a2c_pkg::ADDR_CLOCK_OUTPUT_SELECT};
  logic [7:0] rs[4] = '{a2c_pkg::RST_BITDIV_SOURCE, a2c_pkg::RST_BITDIV_RATIO_POWER,
    a2c_pkg::RST_WORDDIV_RATIO_POWER, a2c_pkg::RST_CLOCK_OUTPUT_SELECT};
  logic [2:0] sc[8] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h2, 3'h5, 3'h7};
  int sp[8] = '{32, 16, 64, 128, 256, 0, 0, 0};
  logic [2:0] oc[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int ob[6] = '{8, 4, 0, 48, 32, 0};
  int ow[6] = '{16, 4, 0, 96, 32, 0};

  // ----------------------------------------
  // Clock, sources, design and receivers
  // ----------------------------------------
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 8'h01;
  a2c_clkgen dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .n_divider_clock_i(cyc[4]), .dac_modulator_clock_i(cyc[3]), .adc_modulator_clock_i(cyc[5]),
    .port1_bitclk_pin_i(cyc[6]), .port2_bitclk_pin_i(cyc[7]), .port1_bitdiv_clk_i(cyc[2]),
    .port1_worddiv_clk_i(cyc[3]), .port1_dac_clk_i(cyc[1]), .port2_dac_clk_i(cyc[4]),
    .port2_bitclk_o(bclk), .port2_wordclk_o(wclk));
  a2c_host_clk_mon bmon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_in_i(bclk), .per_o(bp),
    .meas_o(bv), .edges_o(be));
  a2c_host_clk_mon wmon (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .clk_in_i(wclk), .per_o(wp),
    .meas_o(wv), .edges_o(we));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  // Random value source
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // One request per edge; the next call or idle replaces it
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
  endtask
  task automatic idle();
    @(posedge clock_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // Expected periods in cycles; zero means no rising edge at all
  task automatic meas(input int b, input int w);
    int mx, eb, ew, n;
    idle();
    mx = (b > w) ? b : w;
    repeat (3 * mx + 300) @(posedge clock_i);
    eb = be;
    ew = we;
    if (b != 0) repeat (2) bq.push_back(b);
    if (w != 0) wq.push_back(w);
    n = 0;
    while (bq.size() + wq.size() != 0 && n < 3 * mx + 300) begin
      @(posedge clock_i);
      n++;
    end
    if (n == 0) repeat (300) @(posedge clock_i);
    chk(bq.size() + wq.size() == 0, "period missing");
    if (b == 0) chk(be == eb, "bit clock not quiet");
    if (w == 0) chk(we == ew, "word clock not quiet");
    bq.delete();
    wq.delete();
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Monitor: read data one cycle after the read edge, periods
  // ----------------------------------------
  always @(posedge clock_i) begin
    rd1 <= req.rd;
  end
  always @(negedge clock_i) begin
    if (rd1) chk(rq.size() != 0 && rdata === rq.pop_front(), "read data");
    if (bv && bq.size() != 0) chk(bp == bq.pop_front(), "bit period");
    if (wv && wq.size() != 0) chk(wp == wq.pop_front(), "word period");
  end
  // Hang guard
  always @(posedge clock_i) begin
    tmo <= tmo + 1;
    if (tmo == 80000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    foreach (ad[i]) rd(ad[i], rs[i]);
    bus(1'b1, 8'h25, 8'hA5);
    rd(8'h25, 8'h00);
    foreach (ad[i]) begin
      lf = lfsr_next(lf);
      bus(1'b1, ad[i], lf[7:0]);
      rd(ad[i], lf[7:0]);
    end
    $display("test registers done");
    bus(1'b1, ad[0], 8'h01);
    bus(1'b1, ad[2], 8'h20);
    bus(1'b1, ad[3], 8'h33);
    bus(1'b1, ad[1], 8'h01);
    meas(0, 0);
    bus(1'b1, ad[1], 8'h81);
    foreach (sc[i]) begin
      bus(1'b1, ad[0], {5'h00, sc[i]});
      meas(sp[i], 0);
    end
    $display("test sources done");
    bus(1'b1, ad[0], 8'h01);
    bus(1'b1, ad[1], 8'h83);
    bus(1'b1, ad[2], 8'h02);
    bus(1'b1, ad[2], 8'h82);
    meas(48, 96);
    bus(1'b1, ad[1], 8'h80);
    bus(1'b1, ad[2], 8'h81);
    meas(2048, 2048);
    bus(1'b1, ad[1], 8'h81);
    bus(1'b1, ad[2], 8'h80);
    meas(16, 2048);
    bus(1'b1, ad[1], 8'h01);
    meas(0, 0);
    $display("test dividers done");
    bus(1'b1, ad[1], 8'h83);
    bus(1'b1, ad[2], 8'h82);
    foreach (oc[i]) begin
      bus(1'b1, ad[3], {1'b0, oc[i], 1'b0, oc[i]});
      meas(ob[i], ow[i]);
    end
    $display("test outputs done");
    wrap_up();
  end
endmodule
